// ### rtl/evt_assign_mem.sv
// Purpose: interrupt assignment store, one level per peripheral source
// Assumes: synchronous write, registered read of the whole table
// Notes: loads the default map on reset
`timescale 1ns/1ns
`default_nettype none
`include "evt_cfg.svh"
module evt_assign_mem
  import evt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [3:0] wr_level,
  output logic [71:0] table_q
);
  // default map loaded at reset, rewritten by software afterwards
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      table_q <= `ASSIGN_RESET;
    end else if (wr_en && wr_idx < 5'(`NUM_SOURCES)) begin
      table_q[wr_idx*4 +: 4] <= wr_level;
    end
  end
endmodule
`default_nettype wire

// ### rtl/evt_cfg.svh
// Purpose: constants for the two-stage event controller
// Assumes: one clock, REF_CLK at 250 MHz
// Notes: level numbers are priorities, 0 is the highest
`ifndef EVT_CFG_SVH
`define EVT_CFG_SVH
`define NUM_LEVELS 16
`define NUM_SOURCES 18
`define LVL_EMU 4'h0
`define LVL_RST 4'h1
`define LVL_NMI 4'h2
`define LVL_EXC 4'h3
`define LVL_HWERR 4'h5
`define LVL_TMR 4'h6
`define FIRST_GENERAL 4'h7
`define MASK_RESET 16'h0007
// default assignment, four bits per source, source 0 in the low nibble
`define ASSIGN_RESET 72'hFED_DCC_BBB_AA9_888_877
`endif

// ### rtl/evt_ctrl.sv
// Purpose: system routing stage plus core event stage
// Assumes: requests synchronous to REF_CLK; sequencer returns with RET_STB
// Notes: level wins by lowest number; nested levels kept in pending bits
`timescale 1ns/1ns
`default_nettype none
`include "evt_cfg.svh"
module evt_ctrl
  import evt_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire event_req_t REQ,
  input wire logic ASSIGN_WR,
  input wire logic [4:0] ASSIGN_IDX,
  input wire logic [3:0] ASSIGN_LEVEL,
  input wire logic [15:0] MASK_WR_DATA,
  input wire logic MASK_WR,
  input wire logic RET_STB,
  output event_take_t TAKE,
  output logic EMU_MODE,
  output logic CORE_RESET,
  output logic [15:0] LATCH_BITS,
  output logic [15:0] PENDING_BITS,
  output logic [15:0] MASK_BITS,
  output logic [17:0] SRC_STATUS
);
  logic [71:0] assign_tbl; // current source-to-level map
  logic [15:0] lvl_in; // raw level inputs
  logic [15:0] lvl_prev_q; // previous inputs for edge detect
  logic [15:0] latch_q; // latched events
  logic [15:0] pend_q; // active or nested events
  logic [15:0] mask_q; // enable per event
  logic [15:0] cand; // latched and enabled events
  logic [3:0] win; // winning level
  logic win_ok; // a candidate beats the highest active level
  logic [3:0] cur; // highest active level
  logic cur_ok; // something is active
  event_take_t take_q; // registered entry
  seq_state_t state_q; // entry sequencer state

  // lowest set index is the highest priority
  function automatic logic [4:0] first_set(input logic [15:0] v);
    first_set = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) first_set = 5'(i);
    end
  endfunction

  evt_assign_mem u_mem (
    .clk(REF_CLK),
    .rstn(RSTN),
    .wr_en(ASSIGN_WR),
    .wr_idx(ASSIGN_IDX),
    .wr_level(ASSIGN_LEVEL),
    .table_q(assign_tbl)
  );

  // route every peripheral assigned level 7 or above onto that level, sharing by or
  always_comb begin
    lvl_in = '0;
    for (int s = 0; s < `NUM_SOURCES; s++) begin
      // assignment below level 7 is ignored so sources cannot fake core events
      if (REQ.periph[s] && assign_tbl[s*4 +: 4] >= `FIRST_GENERAL) begin
        lvl_in[assign_tbl[s*4 +: 4]] = 1'b1;
      end
    end
    // dedicated core events bypass the assignment table
    lvl_in[`LVL_EMU] = REQ.emulation_event;
    lvl_in[`LVL_RST] = REQ.rst;
    lvl_in[`LVL_NMI] = REQ.nmi_pin | REQ.wdog_nmi;
    lvl_in[`LVL_EXC] = REQ.exc;
    lvl_in[`LVL_HWERR] = REQ.hw_err;
    lvl_in[`LVL_TMR] = REQ.core_tmr;
  end

  // edge memory; a held level does not relatch after entry
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) lvl_prev_q <= '0;
    else lvl_prev_q <= lvl_in;
  end

  // latch on rising edge, clear when pending sets; a new edge wins
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      latch_q <= '0;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (lvl_in[i] && !lvl_prev_q[i]) latch_q[i] <= 1'b1;
        else if (take_q.take && take_q.level == 4'(i)) latch_q[i] <= 1'b0;
      end
    end
  end

  // mask; emulation, reset and non-maskable stay enabled
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) mask_q <= `MASK_RESET;
    else if (MASK_WR) mask_q <= MASK_WR_DATA | `MASK_RESET;
  end

  // ranking: a candidate must beat the highest active level
  always_comb begin
    logic [4:0] w;
    logic [4:0] c;
    w = 5'h10;
    c = 5'h10;
    cand = latch_q & mask_q;
    c = first_set(pend_q);
    cur = c[3:0];
    cur_ok = !c[4];
    w = first_set(cand);
    win = w[3:0];
    win_ok = !w[4] && (!cur_ok || w[3:0] < cur);
  end

  // entry sequencer: one take pulse, then wait a cycle for latch clear
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      take_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // hold off while a return lands: the ranking still sees the old pending set
          take_q.take <= win_ok && !RET_STB;
          take_q.level <= win;
          if (win_ok && !RET_STB) state_q <= ST_ENTER;
        end
        ST_ENTER: begin
          // latch clear and pending set land on this edge
          take_q.take <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          take_q <= '0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // pending: set on entry, highest active cleared on return
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pend_q <= '0;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (take_q.take && take_q.level == 4'(i)) pend_q[i] <= 1'b1;
        // a return always retires the highest active level; an entry wins
        else if (RET_STB && cur_ok && cur == 4'(i)) pend_q[i] <= 1'b0;
      end
    end
  end

  // status outputs
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      EMU_MODE <= 1'b0;
      CORE_RESET <= 1'b0;
      SRC_STATUS <= '0;
    end else begin
      EMU_MODE <= pend_q[`LVL_EMU];
      // one reset strobe per reset-class entry
      CORE_RESET <= take_q.take && take_q.level == `LVL_RST;
      SRC_STATUS <= REQ.periph;
    end
  end

  assign TAKE = take_q;
  assign LATCH_BITS = latch_q;
  assign PENDING_BITS = pend_q;
  assign MASK_BITS = mask_q;

  // assertions; each one guards a single clause of the contract
  // an entry pulse is high for exactly one cycle
  sequence s_take_pulse;
    take_q.take ##1 !take_q.take;
  endsequence
  // core reset follows a reset-class entry by one edge and lasts one cycle
  sequence s_reset_strobe;
    ##1 CORE_RESET ##1 !CORE_RESET;
  endsequence
  // a rising input on level 9 is latched on the next edge
  a_latch_on_edge: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (lvl_in[9] && !lvl_prev_q[9]) |=> latch_q[9])
    else $error("latch missed edge");
  // the entered level was enabled when the ranking picked it
  a_masked_no_take: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    take_q.take |-> $past(mask_q[win]))
    else $error("masked event taken");
  // entry marks the level active on the following edge
  a_take_sets_pend: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    take_q.take |=> pend_q[$past(take_q.level)])
    else $error("pending not set");
  // entry retires the latch unless a fresh edge arrived meanwhile
  a_take_clears_latch: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (take_q.take && !(lvl_in[take_q.level] && !lvl_prev_q[take_q.level]))
    |=> !latch_q[$past(take_q.level)])
    else $error("latch not cleared");
  // nesting only ever goes to a strictly higher level
  a_preempt_only_higher: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (take_q.take && $past(cur_ok)) |-> take_q.level < $past(cur))
    else $error("lower level preempted");
  // a watchdog request alone is enough to latch the non-maskable level
  a_nmi_routes: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (REQ.wdog_nmi && !lvl_prev_q[`LVL_NMI]) |=> latch_q[`LVL_NMI])
    else $error("watchdog nmi lost");
  // debug mode shows one edge after the emulation level goes active
  a_emu_mode: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    pend_q[`LVL_EMU] |=> EMU_MODE)
    else $error("emulation mode missing");
  // a reset-class entry produces one core reset strobe
  a_reset_pulse: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (take_q.take && take_q.level == `LVL_RST) |-> s_reset_strobe)
    else $error("reset event lost");
  // entries never run back to back
  a_take_spacing: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    take_q.take |-> s_take_pulse)
    else $error("back to back take");
  // a return retires the highest active level
  a_ret_retires: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (RET_STB && cur_ok && !(take_q.take && take_q.level == cur))
    |=> !pend_q[$past(cur)])
    else $error("return did not retire level");
endmodule
`default_nettype wire

// ### rtl/evt_pkg.sv
// Purpose: types for the two-stage event controller
// Assumes: evt_cfg.svh constants
// Notes: none
package evt_pkg;
  typedef logic [15:0] level_vec_t;
  typedef logic [3:0] level_t;
  // source-side request bundle
  typedef struct packed {
    logic [17:0] periph;  // peripheral request levels
    logic nmi_pin;        // non-maskable pin
    logic wdog_nmi;       // watchdog non-maskable
    logic exc;            // synchronous exception
    logic hw_err;         // hardware error
    logic core_tmr;       // core timer
    logic emulation_event;            // emulation request
    logic rst;            // software reset request
  } event_req_t;
  // answer to the sequencer
  typedef struct packed {
    logic take;           // one-cycle event entry pulse
    level_t level;        // level being entered
  } event_take_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ENTER} seq_state_t;
endpackage

// ### verif/evt_seq_model.sv
// Purpose: sequencer stand-in that returns from taken events
// Assumes: one return pulse per entry, after ret_dly idle cycles
// Notes: hold freezes returns so that nesting can build up
`timescale 1ns/1ns
`default_nettype none
module evt_seq_model
  import evt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire event_take_t take,
  input wire logic hold,
  input wire logic [2:0] ret_dly,
  output logic ret_stb
);
  int open_q; // entries not yet returned
  int wait_q; // idle cycles before the next return
  // one return per entry; a gap after each so returns never run back to back
  always @(posedge clk or negedge rstn) begin
    int n;
    if (!rstn) begin
      open_q <= 0;
      wait_q <= 0;
      ret_stb <= 1'b0;
    end else begin
      n = open_q + ((take.take === 1'b1) ? 1 : 0);
      ret_stb <= 1'b0;
      if (hold || n == 0 || ret_stb) begin
        wait_q <= 0;
      end else if (wait_q >= ret_dly) begin
        ret_stb <= 1'b1;
        n = n - 1;
        wait_q <= 0;
      end else begin
        wait_q <= wait_q + 1;
      end
      open_q <= n;
    end
  end
endmodule
`default_nettype wire

// ### verif/two_stage_event_controller_tb_top.sv
// Purpose: self-checking bench for the event controller
// Assumes: inputs change 1 ns after the rising edge
// Notes: expected levels come from the bench's own default table
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module two_stage_event_controller_tb_top
  import evt_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, hold = 1'b0, awr = 1'b0, mwr = 1'b0, ret;
  logic [4:0] aidx = 5'h00;
  logic [3:0] alvl = 4'h0, last_lvl = 4'h0;
  logic [15:0] mdat = 16'h0000, latch, pend, mask;
  logic [2:0] rdly = 3'h0;
  event_req_t req = '0;
  event_take_t take;
  logic emu_mode, core_rst;
  logic [17:0] src_st;
  int bad_count = 0, num_checks = 0, take_cnt = 0, rst_cnt = 0, cyc = 0, s, n;
  level_t tab[18]; // bench copy of the assignment table
  int dbit[7] = '{6, 5, 4, 3, 2, 1, 0}; // nmi pin, watchdog, exc, hw err, timer, emu, rst
  level_t dlvl[7] = '{4'h2, 4'h2, 4'h3, 4'h5, 4'h6, 4'h0, 4'h1};
  always #2 clk = ~clk;
  evt_ctrl u_evt_ctrl (.REF_CLK(clk), .RSTN(rstn), .REQ(req), .ASSIGN_WR(awr),
    .ASSIGN_IDX(aidx), .ASSIGN_LEVEL(alvl), .MASK_WR_DATA(mdat), .MASK_WR(mwr),
    .RET_STB(ret), .TAKE(take), .EMU_MODE(emu_mode), .CORE_RESET(core_rst),
    .LATCH_BITS(latch), .PENDING_BITS(pend), .MASK_BITS(mask), .SRC_STATUS(src_st));
  evt_seq_model u_evt_seq_model (.clk(clk), .rstn(rstn), .take(take), .hold(hold),
    .ret_dly(rdly), .ret_stb(ret));
  // watch the one-cycle outputs on every edge so none is missed
  always @(posedge clk) begin
    cyc++;
    if (take.take === 1'b1) begin
      take_cnt++;
      last_lvl = take.level;
    end
    if (core_rst === 1'b1) rst_cnt++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  // default map, by source position
  function automatic level_t dflt(int i);
    return (i < 2) ? 4'h7 : (i < 6) ? 4'h8 : (i < 7) ? 4'h9 : (i < 9) ? 4'hA :
      (i < 12) ? 4'hB : (i < 14) ? 4'hC : (i < 16) ? 4'hD : (i == 16) ? 4'hE : 4'hF;
  endfunction
  task automatic step(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // a request held for three cycles, then dropped
  task automatic pulse(int b);
    req[b] = 1'b1;
    step(3);
    req[b] = 1'b0;
  endtask
  task automatic exp(level_t l);
    int k;
    for (k = 0; k < 40 && take_cnt == n; k++) step(1);
    `CHK({take_cnt != n, last_lvl}, {1'b1, l})
    n = take_cnt;
  endtask
  task automatic idle(string t);
    int k;
    for (k = 0; k < 60 && pend !== 16'h0000; k++) step(1);
    n = take_cnt;
    $display("test %s done", t);
  endtask
  task automatic setmask(logic [15:0] m);
    mdat = m;
    mwr = 1'b1;
    step(1);
    mwr = 1'b0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hA5A8D827));
    step(6);
    rstn = 1'b1;
    `CHK({mask, pend, take.take}, {16'h0007, 16'h0000, 1'b0})
    setmask(16'hFFFF);
    idle("reset");
    req[7] = 1'b1; // walk: latch on the first edge, entry on the next, pending after
    step(1);
    `CHK(latch[7], 1'b1)
    step(1);
    `CHK({take.take, take.level, latch[7]}, {1'b1, 4'h7, 1'b1})
    step(1);
    `CHK({take.take, pend[7], latch[7]}, 3'b010)
    req[7] = 1'b0;
    idle("walk");
    for (s = 0; s < 18; s++) begin
      tab[s] = dflt(s);
      rdly = 3'($urandom % 5);
      pulse(s + 7);
      exp(tab[s]);
      idle("default");
    end
    for (s = 0; s < 7; s++) begin
      hold = 1'b1;
      pulse(dbit[s]);
      exp(dlvl[s]);
      if (s == 5) begin
        step(1); // mode follows the pending bit by one edge
        `CHK(emu_mode, 1'b1)
      end
      hold = 1'b0;
      idle("dedicated");
    end
    `CHK(rst_cnt, 1)
    setmask(16'h0000); // masked level stays latched but is not entered
    pulse(7);
    step(8);
    `CHK({latch[7], take_cnt == n}, 2'b11)
    setmask(16'hFFFF);
    exp(4'h7);
    idle("mask");
    hold = 1'b1; // nesting and preemption
    pulse(24);
    exp(4'hF);
    pulse(7);
    exp(4'h7);
    `CHK({pend[15], pend[7]}, 2'b11)
    pulse(16);
    step(6);
    `CHK(take_cnt, n)
    hold = 1'b0;
    exp(4'hB);
    idle("nesting");
    req[7] = 1'b1; // a second source on a raised level makes no new edge
    exp(4'h7);
    idle("shared");
    pulse(8);
    step(6);
    `CHK({take_cnt == n, src_st[0]}, 2'b11)
    req[7] = 1'b0;
    step(1); // let the shared level fall on an edge before the next rise
    pulse(8);
    exp(4'h7);
    idle("shared");
    for (s = 0; s < 14; s++) begin // two fixed corner cases, then random ones
      aidx = (s < 2) ? 5'h11 : 5'($urandom % 18);
      alvl = (s == 0) ? 4'h5 : (s == 1) ? 4'hF : 4'($urandom % 12 + 4);
      tab[aidx] = alvl; // below the general range the source is silenced
      awr = 1'b1;
      step(1);
      awr = 1'b0;
      pulse(aidx + 7);
      if (tab[aidx] >= 4'h7) begin
        exp(tab[aidx]);
      end else begin
        step(8);
        `CHK(take_cnt, n)
      end
      idle("assign");
    end
    results();
  end
endmodule
`default_nettype wire
